/* rtl/tmr3_regs.svh */
// Purpose: register offsets, field positions, reset values, divider counts
// Assumes: special-function-register space with 8-bit addresses
// Notes:   definitions only
`ifndef TMR3_REGS_SVH
`define TMR3_REGS_SVH
// register addresses
`define TMR3_CONTROL_ADDR       8'h91
`define TMR3_RELOAD_LOW_ADDR    8'h92
`define TMR3_RELOAD_HIGH_ADDR   8'h93
`define TMR3_COUNT_LOW_ADDR     8'h94
`define TMR3_COUNT_HIGH_ADDR    8'h95
// control field positions
`define TMR3_HIGH_OVF_BIT       7
`define TMR3_LOW_OVF_BIT        6
`define TMR3_LOW_IRQ_EN_BIT     5
`define TMR3_CAPTURE_EN_BIT     4
`define TMR3_SPLIT_BIT          3
`define TMR3_RUN_BIT            2
`define TMR3_UNUSED_BIT         1
`define TMR3_EXT_CLK_BIT        0
// reset values
`define TMR3_CONTROL_RESET      8'h00
`define TMR3_BYTE_RESET         8'h00
// clock divider figures
`define TMR3_SYS_DIV            12
`define TMR3_EXT_DIV            8
`endif

/* rtl/tmr3_pkg.sv */
// Purpose: shared types of the timer 3 block
// Assumes: nothing
// Notes:   constants live in tmr3_regs.svh
package tmr3_pkg;
  // register bus request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tmr3_bus_t;
  // tick source of one counter byte
  typedef enum logic [1:0] {
    TMR3_SRC_SYS,
    TMR3_SRC_SYS12,
    TMR3_SRC_EXT8
  } tmr3_src_t;
endpackage

/* rtl/tmr3_tick_gen.sv */
// Purpose: timer tick sources: system clock /12 and external clock /8
// Assumes: ext_clk_in is a level sampled on mclk, slower than mclk / 2
// Notes:   ext /8 falling edge also serves as capture event
`timescale 1ns/1ps
`default_nettype none
`include "tmr3_regs.svh"
module tmr3_tick_gen #(
  parameter int SYS_DIV = `TMR3_SYS_DIV,
  parameter int EXT_DIV = `TMR3_EXT_DIV
) (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rstn,
  // external oscillator
  input  wire logic ext_clk_in,
  // ticks
  output logic      sys12_tick,
  output logic      ext8_tick,
  output logic      ext8_fall
);
  // refuse dividers that the 8-bit prescalers cannot serve
  if (SYS_DIV < 2 || SYS_DIV > 256 || EXT_DIV < 2 || EXT_DIV > 256 || EXT_DIV % 2 != 0)
  begin
    $error("tmr3_tick_gen: divider out of range");
  end
  localparam logic [7:0] SYS_LAST = 8'(SYS_DIV - 1);
  localparam logic [7:0] EXT_LAST = 8'(EXT_DIV - 1);
  localparam logic [7:0] EXT_HALF = 8'(EXT_DIV / 2 - 1);
  logic [7:0] sys_cnt_reg, sys_cnt_next;   // /12 prescaler
  logic [7:0] ext_cnt_reg, ext_cnt_next;   // external edge counter
  logic       sync1_reg, sync2_reg, sync3_reg; // synchroniser, edge hold
  logic       ext_rise;                        // rising edge of ext clock
  // next-state of the prescalers
  always_comb
  begin
    sys_cnt_next = (sys_cnt_reg == SYS_LAST) ? 8'h00 : sys_cnt_reg + 8'h01;
    ext_rise     = sync2_reg & ~sync3_reg;
    ext_cnt_next = ext_cnt_reg;
    if (ext_rise)
      ext_cnt_next = (ext_cnt_reg == EXT_LAST) ? 8'h00 : ext_cnt_reg + 8'h01;
  end
  // registers; first sync stage feeds only the second
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      sys_cnt_reg <= 8'h00;
      ext_cnt_reg <= 8'h00;
      sync1_reg   <= 1'b0;
      sync2_reg   <= 1'b0;
      sync3_reg   <= 1'b0;
    end
    else
    begin
      sys_cnt_reg <= sys_cnt_next;
      ext_cnt_reg <= ext_cnt_next;
      sync1_reg   <= ext_clk_in;
      sync2_reg   <= sync1_reg;
      sync3_reg   <= sync2_reg;
    end
  end
  // one tick per divided period
  assign sys12_tick = (sys_cnt_reg == SYS_LAST);
  assign ext8_tick  = ext_rise && (ext_cnt_reg == EXT_LAST);
  // divided clock falls halfway through its period
  assign ext8_fall  = ext_rise && (ext_cnt_reg == EXT_HALF);
endmodule
`default_nettype wire

/* rtl/tmr3_timer.sv */
// Purpose: timer 3, 16-bit or dual 8-bit auto-reload counter with capture
// Assumes: sfr bus synchronous to mclk, single-cycle write and read strobes
// Notes:   per-byte clock selects come from the shared clock control reg
`timescale 1ns/1ps
`default_nettype none
`include "tmr3_regs.svh"
module tmr3_timer #(
  parameter int SYS_DIV = `TMR3_SYS_DIV,
  parameter int EXT_DIV = `TMR3_EXT_DIV
) (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              rstn,
  // special function register bus
  input  wire tmr3_pkg::tmr3_bus_t sfr_bus,
  output logic [7:0]             sfr_rdata,
  output logic                   sfr_hit,
  // shared clock control bits and interrupt enable
  input  wire logic              high_byte_clock_select,
  input  wire logic              low_byte_clock_select,
  input  wire logic              timer_irq_enable,
  // external oscillator
  input  wire logic              ext_clk_in,
  // interrupt request level
  output logic                   timer_irq
);
  logic       sys12_tick;               // system clock /12 tick
  logic       ext8_tick;                // external /8 tick
  logic       ext8_fall;                // external /8 falling edge
  logic [7:0] ctrl_reg, ctrl_next;      // control register
  logic [7:0] rl_lo_reg, rl_lo_next;    // reload low
  logic [7:0] rl_hi_reg, rl_hi_next;    // reload high
  logic [7:0] cnt_lo_reg, cnt_lo_next;  // count low
  logic [7:0] cnt_hi_reg, cnt_hi_next;  // count high
  logic [7:0] rdata_next;               // read mux
  logic       tick_lo, tick_hi;         // per-byte count enables
  logic       ovf_lo, ovf_hi;           // rollover events

  // tick sources
  tmr3_tick_gen #(
    .SYS_DIV    (SYS_DIV),
    .EXT_DIV    (EXT_DIV)
  ) u_tick (
    .mclk       (mclk),
    .rstn       (rstn),
    .ext_clk_in (ext_clk_in),
    .sys12_tick (sys12_tick),
    .ext8_tick  (ext8_tick),
    .ext8_fall  (ext8_fall)
  );

  // pick a byte's source from its clock select
  function automatic tmr3_pkg::tmr3_src_t pick_src(input logic byte_sel, input logic ext_sel);
    if (byte_sel)
      return tmr3_pkg::TMR3_SRC_SYS;
    else if (ext_sel)
      return tmr3_pkg::TMR3_SRC_EXT8;
    else
      return tmr3_pkg::TMR3_SRC_SYS12;
  endfunction

  // tick enable for a given source
  function automatic logic src_tick(input tmr3_pkg::tmr3_src_t src, input logic t12,
                                    input logic t8);
    case (src)
      tmr3_pkg::TMR3_SRC_SYS:   return 1'b1;
      tmr3_pkg::TMR3_SRC_SYS12: return t12;
      tmr3_pkg::TMR3_SRC_EXT8:  return t8;
      default:                  return 1'b0;
    endcase
  endfunction

  // counter and register next state
  always_comb
  begin
    logic split;
    logic capture;
    logic run;
    logic lo_ticks;
    split    = ctrl_reg[`TMR3_SPLIT_BIT];
    capture  = ctrl_reg[`TMR3_CAPTURE_EN_BIT];
    run      = ctrl_reg[`TMR3_RUN_BIT];
    lo_ticks = 1'b0;
    // with low clock select clear, ext select picks /12 or /8; when set the byte counts every mclk
    lo_ticks = src_tick(pick_src(low_byte_clock_select, ctrl_reg[`TMR3_EXT_CLK_BIT]),
                        sys12_tick, ext8_tick);
    tick_lo  = split ? lo_ticks : (run & lo_ticks);
    if (split)
      tick_hi = run & src_tick(pick_src(high_byte_clock_select, ctrl_reg[`TMR3_EXT_CLK_BIT]),
                               sys12_tick, ext8_tick);
    else
      tick_hi = tick_lo & (cnt_lo_reg == 8'hFF);
    ovf_lo  = tick_lo & (cnt_lo_reg == 8'hFF);
    ovf_hi  = tick_hi & (cnt_hi_reg == 8'hFF);

    ctrl_next   = ctrl_reg;
    rl_lo_next  = rl_lo_reg;
    rl_hi_next  = rl_hi_reg;
    cnt_lo_next = cnt_lo_reg;
    cnt_hi_next = cnt_hi_reg;

    // counting; in 16-bit mode reload only at full rollover
    if (tick_lo)
      cnt_lo_next = cnt_lo_reg + 8'h01;
    if (tick_hi)
      cnt_hi_next = cnt_hi_reg + 8'h01;
    if (split)
    begin
      if (ovf_lo)
        cnt_lo_next = rl_lo_reg;
      if (ovf_hi)
        cnt_hi_next = rl_hi_reg;
    end
    else if (ovf_hi)
    begin
      cnt_lo_next = rl_lo_reg;
      cnt_hi_next = rl_hi_reg;
    end

    // software writes
    if (sfr_bus.wr)
    begin
      case (sfr_bus.addr)
        `TMR3_CONTROL_ADDR:      ctrl_next   = sfr_bus.wdata;
        `TMR3_RELOAD_LOW_ADDR:   rl_lo_next  = sfr_bus.wdata;
        `TMR3_RELOAD_HIGH_ADDR:  rl_hi_next  = sfr_bus.wdata;
        `TMR3_COUNT_LOW_ADDR:    cnt_lo_next = sfr_bus.wdata;
        `TMR3_COUNT_HIGH_ADDR:   cnt_hi_next = sfr_bus.wdata;
        default:                 ;
      endcase
    end

    if (capture && ext8_fall)
    begin
      rl_lo_next = cnt_lo_reg;
      rl_hi_next = cnt_hi_reg;
    end

    // high rollover or capture sets high flag, low rollover sets low flag, set beats clear
    if (ovf_hi || (capture && ext8_fall))
      ctrl_next[`TMR3_HIGH_OVF_BIT] = 1'b1;
    if (ovf_lo)
      ctrl_next[`TMR3_LOW_OVF_BIT] = 1'b1;
    ctrl_next[`TMR3_UNUSED_BIT] = 1'b0;

    // read data mux
    case (sfr_bus.addr)
      `TMR3_CONTROL_ADDR:      rdata_next = ctrl_reg;
      `TMR3_RELOAD_LOW_ADDR:   rdata_next = rl_lo_reg;
      `TMR3_RELOAD_HIGH_ADDR:  rdata_next = rl_hi_reg;
      `TMR3_COUNT_LOW_ADDR:    rdata_next = cnt_lo_reg;
      `TMR3_COUNT_HIGH_ADDR:   rdata_next = cnt_hi_reg;
      default:                 rdata_next = 8'h00;
    endcase
    if (!sfr_bus.rd)
      rdata_next = 8'h00;
  end

  // registers
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_reg   <= `TMR3_CONTROL_RESET;
      rl_lo_reg  <= `TMR3_BYTE_RESET;
      rl_hi_reg  <= `TMR3_BYTE_RESET;
      cnt_lo_reg <= `TMR3_BYTE_RESET;
      cnt_hi_reg <= `TMR3_BYTE_RESET;
      sfr_rdata  <= 8'h00;
    end
    else
    begin
      ctrl_reg   <= ctrl_next;
      rl_lo_reg  <= rl_lo_next;
      rl_hi_reg  <= rl_hi_next;
      cnt_lo_reg <= cnt_lo_next;
      cnt_hi_reg <= cnt_hi_next;
      sfr_rdata  <= rdata_next;
    end
  end

  // address decode answer
  assign sfr_hit = (sfr_bus.addr >= `TMR3_CONTROL_ADDR) &&
                   (sfr_bus.addr <= `TMR3_COUNT_HIGH_ADDR);

  assign timer_irq = timer_irq_enable &
                     (ctrl_reg[`TMR3_HIGH_OVF_BIT] |
                      (ctrl_reg[`TMR3_LOW_IRQ_EN_BIT] & ctrl_reg[`TMR3_LOW_OVF_BIT]));
endmodule
`default_nettype wire

/* bench/tmr3_timer_checker.sv */
// Purpose: port-level checks of tmr3_timer
// Assumes: one clock domain, rstn async active low
// Notes:   bound to every tmr3_timer instance
`timescale 1ns/1ps
`default_nettype none
module tmr3_timer_checker #(
  parameter int SYS_DIV = 12,
  parameter int EXT_DIV = 8
) (
  // clock and reset
  input wire logic                mclk,
  input wire logic                rstn,
  // register bus
  input wire tmr3_pkg::tmr3_bus_t sfr_bus,
  input wire logic [7:0]          sfr_rdata,
  input wire logic                sfr_hit,
  // side inputs and request
  input wire logic                high_byte_clock_select,
  input wire logic                low_byte_clock_select,
  input wire logic                timer_irq_enable,
  input wire logic                ext_clk_in,
  input wire logic                timer_irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // read of the control register
  sequence ctl_rd;
    sfr_bus.rd && sfr_bus.addr == 8'h91;
  endsequence
  // enabled but no request pending
  sequence irq_quiet;
    timer_irq_enable && !timer_irq;
  endsequence
  hit_decode_a: assert property (sfr_hit == (sfr_bus.addr inside {[8'h91:8'h95]}))
    else $error("address decode wrong");
  rdata_idle_a: assert property (!$past(sfr_bus.rd) |-> sfr_rdata == 8'h00)
    else $error("read data without read");
  unmapped_read_a: assert property (sfr_bus.rd && !sfr_hit |=> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  unused_bit_a: assert property (ctl_rd |=> !sfr_rdata[1])
    else $error("control bit one not zero");
  irq_gate_a: assert property (!timer_irq_enable |-> !timer_irq)
    else $error("request while disabled");
  irq_source_a: assert property (ctl_rd ##0 timer_irq |=>
    sfr_rdata[7] || (sfr_rdata[6] && sfr_rdata[5]))
    else $error("request without flag");
  high_flag_irq_a: assert property (ctl_rd ##0 irq_quiet |=> !sfr_rdata[7])
    else $error("high flag without request");
  flag_sticky_a: assert property (timer_irq && !(sfr_bus.wr && sfr_bus.addr == 8'h91)
    |=> timer_irq || !timer_irq_enable)
    else $error("flag cleared by hardware");
endmodule
bind tmr3_timer tmr3_timer_checker #(.SYS_DIV(SYS_DIV), .EXT_DIV(EXT_DIV)) u_chk (
  .mclk(mclk), .rstn(rstn), .sfr_bus(sfr_bus), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
  .high_byte_clock_select(high_byte_clock_select),
  .low_byte_clock_select(low_byte_clock_select), .timer_irq_enable(timer_irq_enable),
  .ext_clk_in(ext_clk_in), .timer_irq(timer_irq));
`default_nettype wire

/* bench/tb.sv */
// Purpose: self-checking bench of tmr3_timer
// Assumes: 200 MHz mclk, bus driven at rising edge
// Notes:   short runs use the system clock source
`timescale 1ns/1ps
`default_nettype none
module tb;
  // clock, reset, bus
  logic                mclk;
  logic                rstn;
  tmr3_pkg::tmr3_bus_t bus;
  logic [7:0]          rdata;
  logic                hit;
  // side inputs and request
  logic                sel_h;
  logic                sel_l;
  logic                irq_en;
  logic                ext_clk;
  logic                irq;
  // tallies and scratch
  int                  num_errors = 0;
  int                  n_compared = 0;
  logic [7:0]          v;
  tmr3_timer u_tmr3_timer (
    .mclk(mclk), .rstn(rstn), .sfr_bus(bus), .sfr_rdata(rdata), .sfr_hit(hit),
    .high_byte_clock_select(sel_h), .low_byte_clock_select(sel_l),
    .timer_irq_enable(irq_en), .ext_clk_in(ext_clk), .timer_irq(irq));
  // free-running clock
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // verdict and stop
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // compare one value
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk);
    bus <= '0;
  endtask
  // one read strobe, data taken a cycle later into v
  task automatic rd_byte(input logic [7:0] a);
    @(posedge mclk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge mclk);
    bus <= '0;
    #1 v = rdata;
  endtask
  // read and compare
  task automatic rc(input logic [7:0] a, input logic [7:0] e, input string nm);
    rd_byte(a);
    chk(nm, v, e);
  endtask
  // bounded wait for the request, looked at after the edge settles
  task automatic wait_irq(input int n);
    repeat (n)
      if (irq !== 1'b1)
      begin
        @(posedge mclk);
        #1;
      end
    chk("irq wait", {7'h00, irq}, 8'h01);
    if (irq !== 1'b1)
      end_sim();
  endtask
  // main sequence
  initial
  begin
    rstn = 1'b0;
    bus = '0;
    sel_h = 1'b1;
    sel_l = 1'b1;
    irq_en = 1'b1;
    ext_clk = 1'b0;
    repeat (6) @(posedge mclk);
    rstn <= 1'b1;
    // reset values, then one unmapped place
    for (int a = 8'h91; a <= 8'h96; a++)
      rc(a[7:0], 8'h00, "reset");
    wr(8'h91, 8'h3a);
    rc(8'h91, 8'h38, "control");
    wr(8'h91, 8'h00);
    wr(8'h92, 8'ha5);
    wr(8'h93, 8'h5a);
    rc(8'h92, 8'ha5, "reload low");
    rc(8'h93, 8'h5a, "reload high");
    $display("test registers done");
    // 16-bit rollover reloads and sets both flags
    wr(8'h92, 8'h34);
    wr(8'h93, 8'h12);
    wr(8'h94, 8'hfe);
    wr(8'h95, 8'hff);
    wr(8'h91, 8'h04);
    wait_irq(20);
    wr(8'h91, 8'hc0);
    rc(8'h95, 8'h12, "reload on wrap");
    rc(8'h91, 8'hc0, "flags after wrap");
    chk("request", {7'h00, irq}, 8'h01);
    wr(8'h91, 8'h00);
    $display("test wrap done");
    // split: low counts with run off, low request
    wr(8'h94, 8'hf0);
    wr(8'h95, 8'h10);
    wr(8'h92, 8'h00);
    wr(8'h91, 8'h28);
    wait_irq(40);
    rc(8'h91, 8'h68, "split flags");
    wr(8'h91, 8'h00);
    rc(8'h95, 8'h10, "high held");
    // split with run: high byte wraps and sets its flag
    wr(8'h94, 8'h00);
    wr(8'h95, 8'hfd);
    wr(8'h91, 8'h0c);
    wait_irq(20);
    rc(8'h91, 8'h8c, "split high flag");
    wr(8'h91, 8'h00);
    $display("test split done");
    // system clock divided by twelve
    @(posedge mclk);
    sel_h <= 1'b0;
    sel_l <= 1'b0;
    wr(8'h94, 8'h00);
    wr(8'h95, 8'h00);
    wr(8'h91, 8'h04);
    repeat (120) @(posedge mclk);
    wr(8'h91, 8'h00);
    rd_byte(8'h94);
    chk("div twelve", {7'h00, v >= 8'd9 && v <= 8'd11}, 8'h01);
    rc(8'h95, 8'h00, "div twelve high");
    $display("test divider done");
    // capture on external edges
    @(posedge mclk);
    sel_h <= 1'b1;
    sel_l <= 1'b1;
    wr(8'h94, 8'h00);
    wr(8'h92, 8'h00);
    wr(8'h91, 8'h14);
    repeat (24)
    begin
      repeat (4) @(posedge mclk);
      ext_clk <= ~ext_clk;
    end
    rc(8'h91, 8'h94, "capture flag");
    rd_byte(8'h92);
    chk("captured", {7'h00, v != 8'h00}, 8'h01);
    rc(8'h93, 8'h00, "capture high");
    $display("test capture done");
    // external clock divided by eight: 24 rises give 3 ticks
    wr(8'h91, 8'h00);
    @(posedge mclk);
    sel_l <= 1'b0;
    wr(8'h94, 8'h00);
    wr(8'h91, 8'h05);
    repeat (48)
    begin
      repeat (4) @(posedge mclk);
      ext_clk <= ~ext_clk;
    end
    rc(8'h94, 8'h03, "ext eight");
    rc(8'h91, 8'h05, "no capture flag");
    $display("test external done");
    end_sim();
  end
endmodule
`default_nettype wire
